// >>> common/lpmc_consts.svh
// Constants of the low-power mode controller: status word layout,
// reset value and wake settle timing.
// Assumes a 100 MHz ref_clk and a CPU core that owns the stack.
//
// Behaviour
// - Mode comes only from four status bits
// - All bits clear: CPU and enabled clocks run
// - Level0: CPU, main clock stop; others run
// - Level1: loop stops; DC generator conditionally off
// - Level2: sub clock, oscillator stop; generator on
// - Level3: oscillator and DC generator also stop
// - Level4: CPU and every clock stopped
// - Setting a mode bit acts at once
// - Peripherals on stopped clocks stay inactive
// - Sleep entry and exit keep all state
// - Any enabled interrupt wakes any level
// - Entry stacks word, clears halt, gen, osc
// - Return restores popped status word whole
// - Modified stacked word selects resumed mode
// - Mode bits and stack open to any instruction
// - Entry clears word except loop bit
// - Maskable wake needs own and global enable
`ifndef LPMC_CONSTS_SVH
`define LPMC_CONSTS_SVH

// Status word width and bit positions
`define LPMC_SW_W          16
`define LPMC_GIE_BIT       3
`define LPMC_CPU_HALT_BIT  4
`define LPMC_LF_OSC_BIT    5
`define LPMC_LOOP_OFF_BIT  6
`define LPMC_DCO_GEN_BIT   7
`define LPMC_SW_RST        16'h0000

// Oscillator restart time and clock period
`define LPMC_DCO_WAKE_NS   6000
`define LPMC_CLK_NS        10
// Least time, so it rounds up
`define LPMC_SETTLE_CYC    ((`LPMC_DCO_WAKE_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`define LPMC_SETTLE_W      10

`endif

// >>> common/lpmc_pkg.sv
// Types of the low-power mode controller.
// Encodings are literal here; nothing is taken from lpmc_consts.svh.
package lpmc_pkg;

  // Controller state, Gray along run, sleep, wake
  typedef enum logic [1:0] {
    LPMC_RUN   = 2'b00,
    LPMC_SLEEP = 2'b01,
    LPMC_WAKE  = 2'b11
  } lpmc_state_t;

  // Decoded operating mode
  typedef enum logic [2:0] {
    LPMC_ACTIVE = 3'h0,
    LPMC_LVL0   = 3'h1,
    LPMC_LVL1   = 3'h2,
    LPMC_LVL2   = 3'h3,
    LPMC_LVL3   = 3'h4,
    LPMC_LVL4   = 3'h5,
    LPMC_OTHER  = 3'h6
  } lpmc_mode_t;

endpackage

// >>> rtl/lpmc_ctrl.sv
// Low-power mode controller: holds the live status word, decodes
// the four mode bits into clock gates and runs the wake sequence.
// Assumes the CPU core pulses irq_accept and return_from_irq_pop, supplies the
// popped word and keeps the stack itself; accept, return and write
// pulses never overlap in correct use.
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_consts.svh"

module lpmc_ctrl #(
  parameter int unsigned NIRQ      = 8,
  parameter int unsigned SETTLE_CY = `LPMC_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  // Status word write by any instruction
  input  wire logic                  sw_wr_en,
  input  wire logic [`LPMC_SW_W-1:0] sw_wr_data,
  // Interrupt entry and return from the CPU core
  input  wire logic                  irq_accept,
  input  wire logic                  return_from_irq_pop,
  input  wire logic [`LPMC_SW_W-1:0] return_from_irq_data,
  // Interrupt sources
  input  wire logic [NIRQ-1:0]       irq_req,
  input  wire logic [NIRQ-1:0]       irq_en,
  input  wire logic [NIRQ-1:0]       irq_nmi,
  // Clock source configuration
  input  wire logic                  dco_in_use,
  // Peripheral own enables, one per clock
  input  wire logic                  main_periph_on,
  input  wire logic                  sub_periph_on,
  input  wire logic                  aux_periph_on,
  // Status word, stacked copy and decoded mode
  output logic [`LPMC_SW_W-1:0]      status_word_q,
  output logic [`LPMC_SW_W-1:0]      stacked_sw_q,
  output lpmc_pkg::lpmc_mode_t       mode_q,
  // CPU control
  output logic                       cpu_run_q,
  output logic                       wake_req,
  // Clock gates
  output logic                       main_clk_en_q,
  output logic                       sub_clk_en_q,
  output logic                       aux_clk_en_q,
  output logic                       dco_en_q,
  output logic                       dc_gen_en_q,
  output logic                       loop_en_q,
  output logic                       lfxt_en_q,
  // Peripheral activity
  output logic                       main_periph_act_q,
  output logic                       sub_periph_act_q,
  output logic                       aux_periph_act_q
);

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Mode from the four control bits alone
  function automatic lpmc_pkg::lpmc_mode_t mode_of(
    input logic [`LPMC_SW_W-1:0] sw
  );
    logic [3:0] b;
    b = {sw[`LPMC_DCO_GEN_BIT], sw[`LPMC_LOOP_OFF_BIT],
         sw[`LPMC_LF_OSC_BIT], sw[`LPMC_CPU_HALT_BIT]};
    unique case (b)
      4'h0:    mode_of = lpmc_pkg::LPMC_ACTIVE;
      4'h1:    mode_of = lpmc_pkg::LPMC_LVL0;
      4'h5:    mode_of = lpmc_pkg::LPMC_LVL1;
      4'h9:    mode_of = lpmc_pkg::LPMC_LVL2;
      4'hd:    mode_of = lpmc_pkg::LPMC_LVL3;
      4'hf:    mode_of = lpmc_pkg::LPMC_LVL4;
      default: mode_of = lpmc_pkg::LPMC_OTHER;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Status word

  logic [`LPMC_SW_W-1:0] sw_d;     // Next live word
  logic [`LPMC_SW_W-1:0] stk_d;    // Next stacked copy

  // Entry wins over return, return over a plain write
  always_comb begin
    sw_d  = status_word_q;
    stk_d = stacked_sw_q;
    if (irq_accept) begin
      stk_d = status_word_q;
      sw_d  = '0;
      sw_d[`LPMC_LOOP_OFF_BIT] = status_word_q[`LPMC_LOOP_OFF_BIT];
    end else if (return_from_irq_pop) begin
      // Popped word taken whole, edited or not
      sw_d = return_from_irq_data;
    end else if (sw_wr_en) begin
      sw_d = sw_wr_data;
    end
  end

  // Only the word and its stacked copy change; no other state is touched by sleep
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_word_q <= `LPMC_SW_RST;
      stacked_sw_q  <= `LPMC_SW_RST;
    end else begin
      status_word_q <= sw_d;
      stacked_sw_q  <= stk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wake detection

  // Maskable sources also need the global enable
  assign wake_req = |(irq_req & irq_en &
                      (irq_nmi | {NIRQ{status_word_q[`LPMC_GIE_BIT]}}));

  ////////////////////////////////////////////////////////////////////
  // Wake sequence

  lpmc_pkg::lpmc_state_t state_q;  // Controller state
  lpmc_pkg::lpmc_state_t state_d;  // Next state
  logic                  settle_go; // Oscillator restart pulse
  logic                  busy;      // Oscillator not yet stable

  // Settle timer for the restarted oscillator
  lpmc_settle #(
    .W   (`LPMC_SETTLE_W),
    .LEN (SETTLE_CY)
  ) u_settle (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .start   (settle_go),
    .busy    (busy)
  );

  // Halt bit drives sleep at once; a wake restarts clocks first
  always_comb begin
    state_d   = state_q;
    settle_go = 1'b0;
    unique case (state_q)
      lpmc_pkg::LPMC_RUN: begin
        if (sw_d[`LPMC_CPU_HALT_BIT]) begin
          state_d = lpmc_pkg::LPMC_SLEEP;
        end
      end
      lpmc_pkg::LPMC_SLEEP: begin
        if (!sw_d[`LPMC_CPU_HALT_BIT]) begin
          state_d = lpmc_pkg::LPMC_RUN;
        end else if (wake_req) begin
          state_d   = lpmc_pkg::LPMC_WAKE;
          // A stopped oscillator must settle before the fetch
          settle_go = !dco_en_q;
        end
      end
      lpmc_pkg::LPMC_WAKE: begin
        if (!sw_d[`LPMC_CPU_HALT_BIT]) begin
          state_d = lpmc_pkg::LPMC_RUN;
        end else if (!wake_req && !busy) begin
          // Source withdrawn before service: fall back asleep
          state_d = lpmc_pkg::LPMC_SLEEP;
        end
      end
      default: begin
        state_d = lpmc_pkg::LPMC_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= lpmc_pkg::LPMC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock gates

  logic main_d;   // Next main clock gate
  logic sub_d;    // Next sub-main clock gate
  logic aux_d;    // Next auxiliary clock gate
  logic dco_d;    // Next oscillator gate
  logic dcg_d;    // Next DC generator gate
  logic loop_d;   // Next control loop gate
  logic lfxt_d;   // Next crystal gate
  logic run_d;    // Next CPU run

  // Gates follow the next word, so a write acts at the same edge
  always_comb begin
    main_d = !sw_d[`LPMC_CPU_HALT_BIT];
    sub_d  = !sw_d[`LPMC_DCO_GEN_BIT];
    dco_d  = !sw_d[`LPMC_DCO_GEN_BIT];
    loop_d = !sw_d[`LPMC_LOOP_OFF_BIT];
    // Generator off only with the loop off and either the oscillator stopped or no oscillator user
    dcg_d  = !(sw_d[`LPMC_LOOP_OFF_BIT] &&
               (sw_d[`LPMC_DCO_GEN_BIT] || !dco_in_use));
    aux_d  = !sw_d[`LPMC_LF_OSC_BIT];
    lfxt_d = !sw_d[`LPMC_LF_OSC_BIT];
    run_d  = (state_d == lpmc_pkg::LPMC_RUN) && !sw_d[`LPMC_CPU_HALT_BIT];
    if (state_d == lpmc_pkg::LPMC_WAKE) begin
      // Everything the service routine will need runs again
      main_d = 1'b1;
      sub_d  = 1'b1;
      dco_d  = 1'b1;
      dcg_d  = 1'b1;
      aux_d  = 1'b1;
      lfxt_d = 1'b1;
      run_d  = !busy && !settle_go;
    end
  end

  // Gate registers; all clocks run out of reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_clk_en_q <= 1'b1;
      sub_clk_en_q  <= 1'b1;
      aux_clk_en_q  <= 1'b1;
      dco_en_q      <= 1'b1;
      dc_gen_en_q   <= 1'b1;
      loop_en_q     <= 1'b1;
      lfxt_en_q     <= 1'b1;
      cpu_run_q     <= 1'b1;
      mode_q        <= lpmc_pkg::LPMC_ACTIVE;
    end else begin
      main_clk_en_q <= main_d;
      sub_clk_en_q  <= sub_d;
      aux_clk_en_q  <= aux_d;
      dco_en_q      <= dco_d;
      dc_gen_en_q   <= dcg_d;
      loop_en_q     <= loop_d;
      lfxt_en_q     <= lfxt_d;
      cpu_run_q     <= run_d;
      mode_q        <= mode_of(sw_d);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Peripheral activity

  // A peripheral runs only with its clock and its own enable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_periph_act_q <= 1'b0;
      sub_periph_act_q  <= 1'b0;
      aux_periph_act_q  <= 1'b0;
    end else begin
      main_periph_act_q <= main_d && main_periph_on;
      sub_periph_act_q  <= sub_d && sub_periph_on;
      aux_periph_act_q  <= aux_d && aux_periph_on;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  logic sleeping;  // Asleep with no wake under way
  assign sleeping = (state_q == lpmc_pkg::LPMC_SLEEP);

  entry_clear_a: assert property (
    irq_accept |=> !status_word_q[`LPMC_CPU_HALT_BIT] && !status_word_q[`LPMC_GIE_BIT]
      && status_word_q[`LPMC_LOOP_OFF_BIT] == $past(status_word_q[`LPMC_LOOP_OFF_BIT]))
    else $error("status word not cleared on entry");

  entry_stack_a: assert property (
    irq_accept |=> stacked_sw_q == $past(status_word_q) && cpu_run_q)
    else $error("status word not stacked on entry");

  return_from_irq_restore_a: assert property (
    return_from_irq_pop && !irq_accept |=> status_word_q == $past(return_from_irq_data)
      && mode_q == mode_of($past(return_from_irq_data)))
    else $error("popped word not restored");

  sw_write_a: assert property (
    sw_wr_en && !irq_accept && !return_from_irq_pop |=> status_word_q == $past(sw_wr_data))
    else $error("status word write lost");

  halt_now_a: assert property (
    sw_wr_en && !irq_accept && !return_from_irq_pop && sw_wr_data[`LPMC_CPU_HALT_BIT]
      |=> !cpu_run_q && (state_q != lpmc_pkg::LPMC_RUN))
    else $error("halt did not act at once");

  level0_gate_a: assert property (
    sleeping && mode_q == lpmc_pkg::LPMC_LVL0
      |-> !main_clk_en_q && sub_clk_en_q && aux_clk_en_q)
    else $error("level0 gating wrong");

  level1_gen_a: assert property (
    sleeping && mode_q == lpmc_pkg::LPMC_LVL1 && $stable(dco_in_use)
      |-> !loop_en_q && sub_clk_en_q && dc_gen_en_q == dco_in_use)
    else $error("level1 generator gating wrong");

  level2_gate_a: assert property (
    sleeping && mode_q == lpmc_pkg::LPMC_LVL2
      |-> !sub_clk_en_q && !dco_en_q && dc_gen_en_q && aux_clk_en_q)
    else $error("level2 gating wrong");

  level3_gate_a: assert property (
    sleeping && mode_q == lpmc_pkg::LPMC_LVL3
      |-> !dco_en_q && !dc_gen_en_q && aux_clk_en_q)
    else $error("level3 gating wrong");

  level4_off_a: assert property (
    sleeping && mode_q == lpmc_pkg::LPMC_LVL4
      |-> !main_clk_en_q && !sub_clk_en_q && !aux_clk_en_q && !lfxt_en_q && !cpu_run_q)
    else $error("level4 left a clock on");

  active_run_a: assert property (
    state_q == lpmc_pkg::LPMC_RUN && mode_q == lpmc_pkg::LPMC_ACTIVE
      |-> cpu_run_q && main_clk_en_q && sub_clk_en_q && aux_clk_en_q)
    else $error("active mode not running");

  wake_start_a: assert property (
    sleeping && wake_req && status_word_q[`LPMC_CPU_HALT_BIT] && !sw_wr_en
      && !return_from_irq_pop && !irq_accept |=> state_q == lpmc_pkg::LPMC_WAKE && main_clk_en_q)
    else $error("enabled interrupt did not wake");

  wake_stall_a: assert property (
    busy |-> !cpu_run_q)
    else $error("CPU ran before oscillator settled");

  periph_idle_a: assert property (
    !sub_clk_en_q |-> !sub_periph_act_q)
    else $error("peripheral active on stopped clock");

  deep_wake_c: cover property (
    sleeping && mode_q == lpmc_pkg::LPMC_LVL4 && wake_req ##[1:1000] irq_accept);
  return_from_irq_sleep_c: cover property (
    return_from_irq_pop && return_from_irq_data[`LPMC_CPU_HALT_BIT] ##1 sleeping);
  settle_done_c: cover property ($fell(busy) ##1 cpu_run_q);

endmodule
`default_nettype wire

// >>> rtl/lpmc_settle.sv
// Oscillator settle timer: counts down after a restart request.
// Assumes start is a one-cycle pulse on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_consts.svh"

module lpmc_settle #(
  parameter int unsigned W   = `LPMC_SETTLE_W,
  parameter int unsigned LEN = `LPMC_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // Control
  input  wire logic start,
  // Status
  output logic      busy
);

  logic [W-1:0] cnt_q;  // Cycles still to wait
  logic [W-1:0] cnt_d;  // Next count

  // Reload on start, otherwise count down to zero
  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = W'(LEN);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  // Count register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Busy while any cycle is left
  assign busy = (cnt_q != '0);

endmodule
`default_nettype wire

// >>> test/low_power_mode_controller_test.sv
// Self-checking bench of the low-power mode controller.
// Assumes lpmc_ctrl, lpmc_pkg and the CPU stand-in lpmc_cpu_model.
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_controller_test;
  localparam int SET = 4;  // Short settle keeps the wake runs brief

  logic        ref_clk, arst_n, sw_wr_en, dco_in_use;
  logic [15:0] sw_wr_data, return_from_irq_data, status_word_q, stacked_sw_q, ret_clr;
  logic [7:0]  irq_req, irq_en, irq_nmi;
  logic        main_periph_on, sub_periph_on, aux_periph_on;
  logic        irq_accept, return_from_irq_pop, cpu_run_q, wake_req, take_irq, ret_go;
  logic        main_clk_en_q, sub_clk_en_q, aux_clk_en_q, dco_en_q;
  logic        dc_gen_en_q, loop_en_q, lfxt_en_q;
  logic        main_periph_act_q, sub_periph_act_q, aux_periph_act_q;
  logic [3:0]  lat;
  logic [6:0]  gv;          // Gate outputs in the model's order
  lpmc_pkg::lpmc_mode_t mode_q;
  int          num_errors, compares, seed;
  logic [15:0] words [6] = '{16'h0000, 16'h0010, 16'h0050, 16'h0090, 16'h00d0, 16'h00f0};

  assign gv = {main_clk_en_q, sub_clk_en_q, aux_clk_en_q, dco_en_q,
               dc_gen_en_q, loop_en_q, lfxt_en_q};

  lpmc_ctrl #(.NIRQ(8), .SETTLE_CY(SET)) lpmc_ctrl_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .sw_wr_en(sw_wr_en), .sw_wr_data(sw_wr_data),
    .irq_accept(irq_accept), .return_from_irq_pop(return_from_irq_pop), .return_from_irq_data(return_from_irq_data),
    .irq_req(irq_req), .irq_en(irq_en), .irq_nmi(irq_nmi), .dco_in_use(dco_in_use),
    .main_periph_on(main_periph_on), .sub_periph_on(sub_periph_on),
    .aux_periph_on(aux_periph_on), .status_word_q(status_word_q),
    .stacked_sw_q(stacked_sw_q), .mode_q(mode_q), .cpu_run_q(cpu_run_q),
    .wake_req(wake_req), .main_clk_en_q(main_clk_en_q), .sub_clk_en_q(sub_clk_en_q),
    .aux_clk_en_q(aux_clk_en_q), .dco_en_q(dco_en_q), .dc_gen_en_q(dc_gen_en_q),
    .loop_en_q(loop_en_q), .lfxt_en_q(lfxt_en_q), .main_periph_act_q(main_periph_act_q),
    .sub_periph_act_q(sub_periph_act_q), .aux_periph_act_q(aux_periph_act_q));

  lpmc_cpu_model lpmc_cpu_model_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .cpu_run_q(cpu_run_q), .wake_req(wake_req),
    .stacked_sw_q(stacked_sw_q), .take_irq(take_irq), .lat(lat), .ret_go(ret_go),
    .ret_clr(ret_clr), .irq_accept(irq_accept), .return_from_irq_pop(return_from_irq_pop),
    .return_from_irq_data(return_from_irq_data));

  ////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Gates for a word, bitwise: {main, sub, aux, dco, dcgen, loop, lfxt}
  function automatic logic [6:0] gates(input logic [15:0] w, input logic du);
    gates = {~w[4], ~w[7], ~w[5], ~w[7], ~(w[6] & (w[7] | ~du)), ~w[6], ~w[5]};
  endfunction

  // Mode code from the four mode bits, gen/loop/osc/halt
  function automatic logic [7:0] mode_of(input logic [15:0] w);
    case (w[7:4])
      4'h0: mode_of = 8'h00;
      4'h1: mode_of = 8'h01;
      4'h5: mode_of = 8'h02;
      4'h9: mode_of = 8'h03;
      4'hd: mode_of = 8'h04;
      4'hf: mode_of = 8'h05;
      default: mode_of = 8'h06;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Word compare
  task automatic chk_w(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Byte compare for flags, gates and codes
  task automatic chk_b(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Status word write, sw_wr_en held for one cycle; the caller does any check
  task automatic wr(input logic [15:0] w);
    @(posedge ref_clk);
    sw_wr_en   <= 1'b1;
    sw_wr_data <= w;
    @(posedge ref_clk);
    sw_wr_en   <= 1'b0;
    #1;
  endtask

  task automatic check_all(input logic [15:0] w);
    chk_w("status", w, status_word_q);
    chk_b("mode", mode_of(w), {5'h0, mode_q});
    chk_b("gates", {1'b0, gates(w, dco_in_use)}, {1'b0, gv});
    chk_b("run", {7'h0, ~w[4]}, {7'h0, cpu_run_q});
  endtask

  // Sleep, wake by a source, enter, then return with clr edits
  task automatic wake_run(input logic [15:0] w, input logic [15:0] clr);
    int n;
    wr(w);
    @(posedge ref_clk);
    irq_req  <= 8'h04;
    irq_en   <= 8'h04;
    irq_nmi  <= 8'h00;
    take_irq <= 1'b1;
    lat      <= 4'($random(seed) & 3);
    #1;
    chk_b("wake_req", {7'h0, w[3]}, {7'h0, wake_req});
    // Maskable source with global enable off must not wake
    if (!w[3]) begin
      step(3);
      chk_b("asleep", 8'h00, {7'h0, cpu_run_q});
      @(posedge ref_clk);
      irq_nmi <= 8'h04;
      #1;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n == 1) begin
        chk_b("wake_gates", {1'b0, 5'h1f, ~w[6], 1'b1}, {1'b0, gv});
      end
    end while (cpu_run_q !== 1'b1 && n < 40);
    chk_b("wake_cyc", 8'(w[7] ? SET + 2 : 1), 8'(n));
    n = 0;
    while (irq_accept !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      num_errors++;
      close_out();
    end
    @(posedge ref_clk);
    irq_req  <= 8'h00;
    take_irq <= 1'b0;
    #1;
    chk_w("stacked", w, stacked_sw_q);
    check_all(w & 16'h0040);
    @(posedge ref_clk);
    ret_go  <= 1'b1;
    ret_clr <= clr;
    @(posedge ref_clk);
    ret_go  <= 1'b0;
    step(1);
    check_all(w & ~clr);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    seed = 5983;
    num_errors = 0;
    compares = 0;
    {arst_n, sw_wr_en, dco_in_use, take_irq, ret_go} = '0;
    {main_periph_on, sub_periph_on, aux_periph_on} = '0;
    {sw_wr_data, ret_clr, irq_req, irq_en, irq_nmi, lat} = '0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    step(1);
    check_all(16'h0000);
    // Every mode with both oscillator uses and random own enables
    foreach (words[i]) begin
      for (int d = 0; d < 2; d++) begin
        @(posedge ref_clk);
        dco_in_use     <= d[0];
        main_periph_on <= 1'($random(seed));
        sub_periph_on  <= 1'($random(seed));
        aux_periph_on  <= 1'($random(seed));
        wr(words[i]);
        check_all(words[i]);
        step(1);
        chk_b("periph", {5'h0, gv[6] & main_periph_on, gv[5] & sub_periph_on,
              gv[4] & aux_periph_on}, {5'h0, main_periph_act_q, sub_periph_act_q,
              aux_periph_act_q});
        chk_w("stk_kept", 16'h0000, stacked_sw_q);
      end
    end
    wake_run(16'h00d0, 16'h00d0);
    wake_run(16'h00f8, 16'h0000);
    wake_run(16'h0018, 16'h0010);
    // Second reset in mid-run
    @(posedge ref_clk);
    arst_n <= 1'b0;
    step(3);
    check_all(16'h0000);
    @(posedge ref_clk);
    arst_n <= 1'b1;
    step(2);
    chk_w("stk_rst", 16'h0000, stacked_sw_q);
    close_out();
  end

endmodule
`default_nettype wire

// >>> test/lpmc_cpu_model.sv
// CPU core stand-in: accepts interrupts, keeps the stack, issues returns.
// Assumes lpmc_ctrl on the same ref_clk; the bench gives the commands.
`timescale 1ns/1ps
`default_nettype none

module lpmc_cpu_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Controller view
  input  wire logic        cpu_run_q,
  input  wire logic        wake_req,
  input  wire logic [15:0] stacked_sw_q,
  // Bench commands
  input  wire logic        take_irq,
  input  wire logic [3:0]  lat,
  input  wire logic        ret_go,
  input  wire logic [15:0] ret_clr,
  // Entry and return pulses
  output logic             irq_accept,
  output logic             return_from_irq_pop,
  output logic [15:0]      return_from_irq_data
);
  logic [15:0] stack_q [$];  // Pushed words, top at the back
  logic        push_q;       // Stacked copy is valid one cycle after entry
  int          wait_n;       // Cycles spent before answering
  logic        want;         // Entry conditions met this cycle

  ////////////////////////////////////////////////////////////////////
  // The core moves the status word whole, never in bytes
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_accept <= 1'b0;
      return_from_irq_pop   <= 1'b0;
      return_from_irq_data  <= 16'h0000;
      push_q     <= 1'b0;
      wait_n = 0;
      want   = 1'b0;
    end else begin
      push_q     <= irq_accept;
      if (push_q) begin
        stack_q.push_back(stacked_sw_q);
      end
      // Entry only once the controller lets the core run, after lat cycles
      want = take_irq && cpu_run_q && wake_req && !irq_accept && !push_q;
      irq_accept <= want && (wait_n >= int'(lat));
      if (want) begin
        wait_n = (wait_n >= int'(lat)) ? 0 : wait_n + 1;
      end
      // Return pops the top word with the routine's edits applied
      if (ret_go && stack_q.size() > 0) begin
        return_from_irq_pop  <= 1'b1;
        return_from_irq_data <= stack_q.pop_back() & ~ret_clr;
      end else begin
        return_from_irq_pop  <= 1'b0;
        // Released bus: never the last value, so stale data cannot pass
        return_from_irq_data <= ~return_from_irq_data;
      end
    end
  end

endmodule
`default_nettype wire
